/* hw/lrg_consts.svh */
`ifndef LRG_CONSTS_SVH
`define LRG_CONSTS_SVH

// ********************************************************************
// Timing
// ********************************************************************
`define LRG_CLK_PERIOD_NS 10
`define LRG_MAX_WIDTH_NS 100000
`define LRG_MAX_DUTY_PCT 8'h46
`define LRG_PCT_SCALE 8'h64

// ********************************************************************
// Register byte offsets
// ********************************************************************
`define LRG_OFS_WIDTH_LIM 5'h00
`define LRG_OFS_DUTY_LIM 5'h04
`define LRG_OFS_STATE 5'h08
`define LRG_OFS_IRQ_STAT 5'h0C
`define LRG_OFS_IRQ_MASK 5'h10
`define LRG_OFS_LAST_WIDTH 5'h14
`define LRG_OFS_LAST_PERIOD 5'h18

// ********************************************************************
// Field positions
// ********************************************************************
`define LRG_BIT_EV_TRIP 0
`define LRG_BIT_EV_DUTY 1
`define LRG_BIT_EV_REFL 2
`define LRG_ST_BIT_TRIP 0
`define LRG_ST_BIT_RUN 1
`define LRG_ST_BIT_DUTY 2
`define LRG_ST_BIT_REFL 3
`define LRG_ST_BIT_LASER 4
`define LRG_ST_BIT_GATE 5
`define LRG_ST_BIT_PERMIT 6

// ********************************************************************
// Widths and reset values
// ********************************************************************
`define LRG_CNT_W 24
`define LRG_EV_W 3
`define LRG_SYNC_W 5
`define LRG_IRQ_MASK_RST 3'h0

`endif

/* hw/lrg_gate.sv */
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

`include "lrg_consts.svh"

// Functional notes
// RULE1: Laser output only while gate is high
// RULE2: Controller grants permit after main supply up
// RULE3: Fault cleared by opening then closing permit
// RULE4: After fault, stay inhibited until clear sequence
// RULE5: Latched-trip output high while fault present
// RULE6: Overrun flags meaningful only while gate high
// RULE7: Duty flag and inhibit over violating portion
// RULE8: Flags low while gate high within limits
// RULE9: Both flags low whenever gate low
// RULE10: Reflection flag raised when protection engages
// RULE11: Reflection flag and suppression during protection only
// RULE12: Controller restores permit with main supply
// RULE13: Permit is not a safety interlock
// RULE14: Temperature/shutter faults latch until cleared and resequenced
// RULE15: Truncate gate pulses at maximum width
// RULE16: Duty is width over period, percent
// RULE17: Temperature/shutter fault trips immediately
// RULE18: Width and duty limits held in cycles; the duty limit is held in percent instead
// RULE19: Gate and permit synchronised before use
module lrg_gate #(
    parameter int P_MAX_WIDTH_CYC = `LRG_MAX_WIDTH_NS / `LRG_CLK_PERIOD_NS
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_gate,
    input wire logic i_run_permit,
    input wire logic i_reflect_trip,
    input wire logic i_temp_fault,
    input wire logic i_shutter_fault,
    output logic o_laser_on,
    output logic o_duty_overrun_flag,
    output logic o_reflection_overrun_flag,
    output logic o_latched_trip,
    output logic o_irq,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest
);

    localparam int CW = `LRG_CNT_W;
    localparam int PW = CW + 8;
    localparam logic [CW-1:0] WIDTH_LIM_RST = CW'(P_MAX_WIDTH_CYC);
    localparam logic [CW-1:0] CNT_MAX = {CW{1'b1}};

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    logic [`LRG_SYNC_W-1:0] sync_vec;
    logic gate_s;
    logic permit_s;
    logic refl_s;
    logic temp_s;
    logic shut_s;

    // RULE19: two-flop input sync
    lrg_sync #(
        .WIDTH(`LRG_SYNC_W)
    ) u_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async({i_gate, i_run_permit, i_reflect_trip, i_temp_fault, i_shutter_fault}),
        .o_sync(sync_vec)
    );

    assign gate_s = sync_vec[4];
    assign permit_s = sync_vec[3];
    assign refl_s = sync_vec[2];
    assign temp_s = sync_vec[1];
    assign shut_s = sync_vec[0];

    // ****************************************************************
    // Registers and bus handshake
    // ****************************************************************
    logic ack_q;
    logic wr_go;
    logic rd_go;
    logic [CW-1:0] width_lim_q;
    logic [7:0] duty_lim_q;
    logic [`LRG_EV_W-1:0] irq_stat_q;
    logic [`LRG_EV_W-1:0] irq_mask_q;
    logic [`LRG_EV_W-1:0] events;
    logic [31:0] rd_d;

    // One wait state for every access; read data registered at the ack edge
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
    assign wr_go = i_avs_write & ack_q;
    assign rd_go = i_avs_read & ~ack_q;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
        end
    end

    // RULE18: width limit held in cycles, duty limit held in percent
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            width_lim_q <= WIDTH_LIM_RST;
            duty_lim_q <= `LRG_MAX_DUTY_PCT;
        end else if (wr_go) begin
            if (i_avs_address == `LRG_OFS_WIDTH_LIM) begin
                width_lim_q <= i_avs_writedata[CW-1:0];
            end else if (i_avs_address == `LRG_OFS_DUTY_LIM) begin
                duty_lim_q <= i_avs_writedata[7:0];
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_mask_q <= `LRG_IRQ_MASK_RST;
        end else if (wr_go && i_avs_address == `LRG_OFS_IRQ_MASK) begin
            irq_mask_q <= i_avs_writedata[`LRG_EV_W-1:0];
        end
    end

    // Set beats a simultaneous write-one-to-clear
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_stat_q <= '0;
        end else if (wr_go && i_avs_address == `LRG_OFS_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~i_avs_writedata[`LRG_EV_W-1:0]) | events;
        end else begin
            irq_stat_q <= irq_stat_q | events;
        end
    end

    assign o_irq = |(irq_stat_q & irq_mask_q);

    // ****************************************************************
    // Fault sequencing
    // ****************************************************************
    lrg_pkg::lrg_state_type state_q;
    logic fault_now;
    logic run;

    assign fault_now = temp_s | shut_s;

    // RULE4: leave fault only via open then close
    // RULE14: close with conditions clear restores run
    // RULE17: fault trips at once
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= lrg_pkg::LRG_WAIT_PERMIT;
        end else begin
            case (state_q)
                lrg_pkg::LRG_WAIT_PERMIT: begin
                    if (fault_now) begin
                        state_q <= lrg_pkg::LRG_FAULT_HELD;
                    end else if (permit_s) begin
                        state_q <= lrg_pkg::LRG_RUN;
                    end
                end
                lrg_pkg::LRG_RUN: begin
                    if (fault_now) begin
                        state_q <= lrg_pkg::LRG_FAULT_HELD;
                    end else if (!permit_s) begin
                        state_q <= lrg_pkg::LRG_WAIT_PERMIT;
                    end
                end
                lrg_pkg::LRG_FAULT_HELD: begin
                    if (!permit_s) begin
                        state_q <= lrg_pkg::LRG_FAULT_OPEN;
                    end
                end
                lrg_pkg::LRG_FAULT_OPEN: begin
                    // RULE3: close after open clears
                    if (permit_s && !fault_now) begin
                        state_q <= lrg_pkg::LRG_RUN;
                    end
                end
                default: begin
                    state_q <= lrg_pkg::LRG_FAULT_HELD;
                end
            endcase
        end
    end

    // Permit alone never stands in for a safety interlock; a fault still trips
    // RULE13: run needs no-fault too
    assign run = (state_q == lrg_pkg::LRG_RUN) && !fault_now;

    // RULE5: trip output follows latch
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_latched_trip <= 1'b0;
        end else begin
            o_latched_trip <= (state_q == lrg_pkg::LRG_FAULT_HELD) ||
                (state_q == lrg_pkg::LRG_FAULT_OPEN) || fault_now;
        end
    end

    // ****************************************************************
    // Pulse width and period measurement
    // ****************************************************************
    logic gate_d_q;
    logic gate_rise;
    logic gate_fall;
    logic [CW-1:0] width_cnt_q;
    logic [CW-1:0] period_cnt_q;
    logic [CW-1:0] last_width_q;
    logic [CW-1:0] last_period_q;

    assign gate_rise = gate_s & ~gate_d_q;
    assign gate_fall = ~gate_s & gate_d_q;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            gate_d_q <= 1'b0;
        end else begin
            gate_d_q <= gate_s;
        end
    end

    // Cleared between pulses so no stale count flags a new pulse; saturates rather than wraps
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            width_cnt_q <= '0;
        end else if (!gate_s) begin
            width_cnt_q <= '0;
        end else if (width_cnt_q != CNT_MAX) begin
            width_cnt_q <= width_cnt_q + CW'(1);
        end
    end

    // RULE16: period is rise to rise
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            period_cnt_q <= '0;
            last_period_q <= '0;
        end else if (gate_rise) begin
            period_cnt_q <= CW'(1);
            last_period_q <= period_cnt_q;
        end else if (period_cnt_q != CNT_MAX && period_cnt_q != '0) begin
            period_cnt_q <= period_cnt_q + CW'(1);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            last_width_q <= '0;
        end else if (gate_fall) begin
            last_width_q <= width_cnt_q;
        end
    end

    // ****************************************************************
    // Limit checks
    // ****************************************************************
    logic width_viol;
    logic duty_viol;
    logic [PW-1:0] width_pct;
    logic [PW-1:0] duty_allow;

    // RULE15: cut at maximum width
    assign width_viol = gate_s && (width_cnt_q >= width_lim_q);

    // Previous period is the estimate; the first pulse has none and is width-checked only
    // RULE16: width*100 against limit*period
    assign width_pct = PW'(width_cnt_q) * PW'(`LRG_PCT_SCALE);
    assign duty_allow = PW'(last_period_q) * PW'(duty_lim_q);
    assign duty_viol = gate_s && (last_period_q != '0) && (width_pct > duty_allow);

    // ****************************************************************
    // Output gating and flags
    // ****************************************************************
    logic duty_flag_d;
    logic refl_flag_d;

    // RULE7: flag only violating portion
    // RULE9: low with gate low
    assign duty_flag_d = gate_s & (width_viol | duty_viol);
    // RULE10: protection raises flag
    // RULE11: only while protection active
    assign refl_flag_d = gate_s & refl_s;

    // RULE6: flags qualified by gate
    // RULE8: low when within limits
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_duty_overrun_flag <= 1'b0;
            o_reflection_overrun_flag <= 1'b0;
        end else begin
            o_duty_overrun_flag <= duty_flag_d;
            o_reflection_overrun_flag <= refl_flag_d;
        end
    end

    // RULE1: output only with gate
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_laser_on <= 1'b0;
        end else begin
            o_laser_on <= gate_s & run & ~duty_flag_d & ~refl_flag_d;
        end
    end

    // ****************************************************************
    // Interrupt events
    // ****************************************************************
    logic trip_d_q;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            trip_d_q <= 1'b0;
        end else begin
            trip_d_q <= o_latched_trip;
        end
    end

    always_comb begin
        events = '0;
        events[`LRG_BIT_EV_TRIP] = o_latched_trip & ~trip_d_q;
        events[`LRG_BIT_EV_DUTY] = duty_flag_d & ~o_duty_overrun_flag;
        events[`LRG_BIT_EV_REFL] = refl_flag_d & ~o_reflection_overrun_flag;
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    always_comb begin
        rd_d = 32'h0000_0000;
        if (i_avs_address == `LRG_OFS_WIDTH_LIM) begin
            rd_d[CW-1:0] = width_lim_q;
        end else if (i_avs_address == `LRG_OFS_DUTY_LIM) begin
            rd_d[7:0] = duty_lim_q;
        end else if (i_avs_address == `LRG_OFS_STATE) begin
            rd_d[`LRG_ST_BIT_TRIP] = o_latched_trip;
            rd_d[`LRG_ST_BIT_RUN] = run;
            rd_d[`LRG_ST_BIT_DUTY] = o_duty_overrun_flag;
            rd_d[`LRG_ST_BIT_REFL] = o_reflection_overrun_flag;
            rd_d[`LRG_ST_BIT_LASER] = o_laser_on;
            rd_d[`LRG_ST_BIT_GATE] = gate_s;
            rd_d[`LRG_ST_BIT_PERMIT] = permit_s;
        end else if (i_avs_address == `LRG_OFS_IRQ_STAT) begin
            rd_d[`LRG_EV_W-1:0] = irq_stat_q;
        end else if (i_avs_address == `LRG_OFS_IRQ_MASK) begin
            rd_d[`LRG_EV_W-1:0] = irq_mask_q;
        end else if (i_avs_address == `LRG_OFS_LAST_WIDTH) begin
            rd_d[CW-1:0] = last_width_q;
        end else if (i_avs_address == `LRG_OFS_LAST_PERIOD) begin
            rd_d[CW-1:0] = last_period_q;
        end
    end

    // Unmapped addresses answer with zero
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (rd_go) begin
            o_avs_readdata <= rd_d;
        end
    end

endmodule

`default_nettype wire

/* hw/lrg_pkg.sv */
package lrg_pkg;

    // Run-permit and fault sequencing
    typedef enum logic [1:0] {
        LRG_WAIT_PERMIT,
        LRG_RUN,
        LRG_FAULT_HELD,
        LRG_FAULT_OPEN
    } lrg_state_type;

endpackage

/* hw/lrg_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module lrg_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;

    // Second stage is the only reader of the first
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule

`default_nettype wire

/* tb/laser_realtime_gate_and_fault_test.sv */
`timescale 1ns/100ps
`default_nettype none
module laser_realtime_gate_and_fault_test;
    logic i_clk, i_reset, i_gate, i_run_permit, i_reflect_trip, i_temp_fault, i_shutter_fault;
    logic o_laser_on, o_duty_overrun_flag, o_reflection_overrun_flag, o_latched_trip, o_irq;
    logic [4:0] i_avs_address;
    logic i_avs_read, i_avs_write, o_avs_waitrequest, pwr, en, clr, go, busy, gprev;
    logic [31:0] i_avs_writedata, o_avs_readdata, rd;
    int hi_q, lo_q, open_q, nl, nd, nr, nov, since, lastp, seen, f, fail_count, tests_run;
    int lim = 20;
    lrg_gate u_lrg_gate (.i_clk(i_clk), .i_reset(i_reset), .i_gate(i_gate),
        .i_run_permit(i_run_permit), .i_reflect_trip(i_reflect_trip), .i_temp_fault(i_temp_fault),
        .i_shutter_fault(i_shutter_fault), .o_laser_on(o_laser_on),
        .o_duty_overrun_flag(o_duty_overrun_flag), .o_latched_trip(o_latched_trip),
        .o_reflection_overrun_flag(o_reflection_overrun_flag), .o_irq(o_irq),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest));
    lrg_ctrl_model u_lrg_ctrl_model (.i_clk(i_clk), .i_power_ok(pwr), .i_enable(en),
        .i_clear(clr), .i_go(go), .i_hi(hi_q), .i_lo(lo_q), .i_open(open_q), .o_gate(i_gate),
        .o_permit(i_run_permit), .o_busy(busy));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // ****
    // Reference counts of stimulus and outputs
    // ****
    always @(posedge i_clk) begin
        nl += (o_laser_on === 1'b1);
        nd += (o_duty_overrun_flag === 1'b1);
        nr += (o_reflection_overrun_flag === 1'b1);
        nov += (i_gate === 1'b1 && i_reflect_trip === 1'b1);
        if (i_gate && !gprev) begin
            lastp = seen ? since : 0;
            since = 1;
            seen = 1;
        end else begin
            since = since + 1;
        end
        gprev = i_gate;
    end
    task automatic summarize();
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_read <= !wr;
        i_avs_write <= wr;
        n = 0;
        @(posedge i_clk);
        while (o_avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 50) begin
            chk("bus wait", 32'h0000_0000, 32'h0000_0001);
            summarize();
        end
        rd = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask
    // Expected counts follow from the measured period, the width limit and the overlap
    task automatic pulse(input int hi, input int lo, input int rs, input int rl, input bit run);
        int l0, d0, r0, v0, a, n;
        @(negedge i_clk);
        l0 = nl;
        d0 = nd;
        r0 = nr;
        v0 = nov;
        @(posedge i_clk);
        hi_q <= hi;
        lo_q <= lo;
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        n = 0;
        while ((busy === 1'b1 || n == 0) && n < 300) begin
            i_reflect_trip <= (n >= rs && n < rs + rl);
            @(posedge i_clk);
            n++;
        end
        if (n >= 300) begin
            chk("pulse wait", 32'h0000_0000, 32'h0000_0001);
            summarize();
        end
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        a = hi < lim ? hi : lim;
        if (lastp > 0 && lastp * 70 / 100 + 1 < a) begin
            a = lastp * 70 / 100 + 1;
        end
        chk("laser cycles", run ? a - (nov - v0) : 0, nl - l0);
        chk("duty cycles", hi - a, nd - d0);
        chk("refl cycles", nov - v0, nr - r0);
    endtask
    initial begin
        {i_reset, i_reflect_trip, i_temp_fault, i_shutter_fault} = 4'h8;
        {i_avs_read, i_avs_write, pwr, en, clr, go, gprev} = 7'h00;
        {i_avs_address, i_avs_writedata} = 37'h0;
        {hi_q, lo_q, open_q, nl, nd, nr, nov, since, lastp, seen, fail_count, tests_run} = '0;
        void'($urandom(32'h21c0));
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        @(negedge i_clk);
        chk("trip", 32'h0000_0000, 32'(o_latched_trip));
        rdchk(5'h00, 32'h0000_2710, "width limit");
        rdchk(5'h04, 32'h0000_0046, "duty limit");
        rdchk(5'h10, 32'h0000_0000, "irq mask");
        bus(1'b1, 5'h1c, 32'hffff_ffff);
        rdchk(5'h1c, 32'h0000_0000, "unmapped");
        bus(1'b1, 5'h00, 32'h0000_0014);
        rdchk(5'h00, 32'h0000_0014, "width limit");
        en <= 1'b1;
        pulse(5, 5, 0, 0, 0);
        @(posedge i_clk);
        pwr <= 1'b1;
        repeat (6) @(posedge i_clk);
        pulse(5, 20, 0, 0, 1);
        pulse(30, 10, 0, 0, 1);
        lim = 40;
        bus(1'b1, 5'h00, 32'h0000_0028);
        pulse(40, 3, 0, 0, 1);
        for (f = 0; f < 6; f++) begin
            pulse(3 + $urandom % 58, 3 + $urandom % 10, 0, 0, 1);
        end
        pulse(10, 10, 3, 4, 1);
        rdchk(5'h14, 32'h0000_000a, "last width");
        rdchk(5'h18, 32'(lastp), "last period");
        rdchk(5'h08, 32'h0000_0042, "state");
        rdchk(5'h0c, 32'h0000_0006, "irq status");
        chk("irq masked", 32'h0000_0000, 32'(o_irq));
        bus(1'b1, 5'h10, 32'h0000_0007);
        @(negedge i_clk);
        chk("irq", 32'h0000_0001, 32'(o_irq));
        bus(1'b1, 5'h0c, 32'h0000_0007);
        rdchk(5'h0c, 32'h0000_0000, "irq cleared");
        chk("irq idle", 32'h0000_0000, 32'(o_irq));
        for (f = 0; f < 2; f++) begin
            @(posedge i_clk);
            {i_shutter_fault, i_temp_fault} <= f ? 2'b10 : 2'b01;
            repeat (5) @(posedge i_clk);
            {i_shutter_fault, i_temp_fault} <= 2'b00;
            @(negedge i_clk);
            chk("trip set", 32'h0000_0001, 32'(o_latched_trip));
            pulse(5, 5, 0, 0, 0);
            @(posedge i_clk);
            open_q <= f ? 8 : 2;
            clr <= 1'b1;
            @(posedge i_clk);
            clr <= 1'b0;
            repeat (16) @(posedge i_clk);
            @(negedge i_clk);
            chk("trip clear", 32'h0000_0000, 32'(o_latched_trip));
            pulse(5, 5, 0, 0, 1);
        end
        summarize();
    end
endmodule
`default_nettype wire

/* tb/lrg_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// Controller model
// ****
module lrg_ctrl_model (
    input wire logic i_clk,
    input wire logic i_power_ok,
    input wire logic i_enable,
    input wire logic i_clear,
    input wire logic i_go,
    input var int i_hi,
    input var int i_lo,
    input var int i_open,
    output logic o_gate,
    output logic o_permit,
    output logic o_busy
);
    int n = 0;
    int open_q = 0;
    logic gate_q = 1'b0;
    logic busy_q = 1'b0;
    assign o_gate = gate_q;
    assign o_busy = busy_q;
    // Permit tied to power, never used as interlock
    assign o_permit = i_power_ok && i_enable && open_q == 0;
    always @(posedge i_clk) begin
        if (i_clear) begin
            open_q <= i_open;
        end else if (open_q > 0) begin
            open_q <= open_q - 1;
        end
        if (i_go) begin
            busy_q <= 1'b1;
            n <= 0;
        end else if (busy_q) begin
            gate_q <= (n < i_hi);
            n <= n + 1;
            if (n == i_hi + i_lo) begin
                busy_q <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/lrg_gate_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// Port checker
// ****
module lrg_gate_properties (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_gate,
    input wire logic i_run_permit,
    input wire logic i_reflect_trip,
    input wire logic i_temp_fault,
    input wire logic i_shutter_fault,
    input wire logic o_laser_on,
    input wire logic o_duty_overrun_flag,
    input wire logic o_reflection_overrun_flag,
    input wire logic o_latched_trip,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Saturating count of cycles with permit held closed
    logic [3:0] perm_q;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            perm_q <= 4'h0;
        end else if (!i_run_permit) begin
            perm_q <= 4'h0;
        end else if (perm_q != 4'hf) begin
            perm_q <= perm_q + 4'h1;
        end
    end
    property p_refl;
        o_reflection_overrun_flag == $past(i_gate && i_reflect_trip, 3);
    endproperty
    a_refl: assert property (p_refl) else $error("reflection flag off");
    property p_low;
        !$past(i_gate, 3) |-> !o_duty_overrun_flag && !o_reflection_overrun_flag;
    endproperty
    a_low: assert property (p_low) else $error("flag high with gate low");
    property p_laser;
        o_laser_on |-> $past(i_gate, 3) && !o_duty_overrun_flag && !o_reflection_overrun_flag
            && !o_latched_trip;
    endproperty
    a_laser: assert property (p_laser) else $error("laser on when barred");
    property p_trip_rise;
        (i_temp_fault || i_shutter_fault) |-> ##3 o_latched_trip;
    endproperty
    a_trip_rise: assert property (p_trip_rise) else $error("trip late");
    // A latch can only clear after permit has been seen open
    property p_trip_hold;
        o_latched_trip && perm_q == 4'hf |=> o_latched_trip;
    endproperty
    a_trip_hold: assert property (p_trip_hold) else $error("trip cleared early");
    property p_duty_hold;
        o_duty_overrun_flag && $past(i_gate, 2) && $past(i_gate) && i_gate |=> o_duty_overrun_flag;
    endproperty
    a_duty_hold: assert property (p_duty_hold) else $error("duty flag dropped");
    property p_wait;
        $rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state count off");
    property p_idle;
        !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest;
    endproperty
    a_idle: assert property (p_idle) else $error("wait while idle");
    c_duty: cover property (o_duty_overrun_flag);
    c_refl: cover property (o_reflection_overrun_flag);
    c_trip: cover property ($fell(o_latched_trip));
endmodule
bind lrg_gate lrg_gate_properties u_lrg_gate_properties (.i_clk(i_clk), .i_reset(i_reset),
    .i_gate(i_gate), .i_run_permit(i_run_permit), .i_reflect_trip(i_reflect_trip),
    .i_temp_fault(i_temp_fault), .i_shutter_fault(i_shutter_fault), .o_laser_on(o_laser_on),
    .o_duty_overrun_flag(o_duty_overrun_flag), .o_latched_trip(o_latched_trip),
    .o_reflection_overrun_flag(o_reflection_overrun_flag), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest));
`default_nettype wire
